// ==== rtl/cap_config_access_port.v ====
// Configuration access port: address register, data window decode and cycle routing
`timescale 1ns/10ps
`include "cap_consts.vh"
// Notes on behaviour
// - Registers take byte, word or dword; address register only dword.
// - Multi-byte fields are little-endian, low byte lane holds low bits.
// - Writes to read-only bits leave them unchanged.
// - Write-one-clear bits clear on a written 1; a 0 changes nothing.
// - Reserved configuration locations still complete the host cycle.
// - Hard reset loads every configuration register with its default.
// - Byte or word access at the address port goes to PCI as I/O.
// - 32-bit read/write address register, reset to zero.
// - Top bit of address register enables the data window.
// - Two logical register sets: host bridge and virtual PCI bridge.
// - Implements configuration mechanism one: address port plus data window.
// - Enabled data window accesses map to selected configuration space.
// - Own devices answer function zero only; others master abort.
// - Bus zero, not own device: type 0 configuration cycle on PCI.
// - Register select drives address lines 7 to 2 of config cycles.
module cap_config_access_port #(
	parameter NREGS = 64,
	parameter AW    = 6
) (
	// Clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rstn,
	// Host I/O cycle
	input  wire        i_io_req,
	input  wire        i_io_wr,
	input  wire [15:0] i_io_addr,
	input  wire [3:0]  i_io_be,
	input  wire [31:0] i_io_wdata,
	output wire        o_io_done,
	output reg  [31:0] o_io_rdata,
	// Hardware event bits for write-one-clear fields
	input  wire [31:0] i_host_set,
	input  wire [31:0] i_vbr_set,
	// Forwarded cycle toward PCI or graphics port
	output reg         o_fwd_valid,
	output reg         o_fwd_io,
	output reg         o_fwd_cfg_type0,
	output reg         o_fwd_cfg_type1,
	output reg         o_fwd_master_abort,
	output reg  [31:0] o_fwd_addr,
	output reg         o_fwd_wr,
	output reg  [3:0]  o_fwd_be,
	output reg  [31:0] o_fwd_wdata,
	// Address register state
	output wire        o_config_enable_bit,
	output wire [31:0] o_config_address_reg
);
	reg  [31:0] config_address_reg_q;
	reg  [31:0] ram_q [0:NREGS-1];
	wire [31:0] host_word;
	wire [31:0] vbr_word;
	wire [7:0]  bus_select;
	wire [4:0]  dev_select;
	wire [2:0]  function_select;
	wire [5:0]  register_select;
	wire        hit_addr;
	wire        hit_win;
	wire        addr_dword;
	wire        own_dev;
	wire        host_dev;
	wire        vbr_dev;
	wire        own_access;
	wire        reg0_sel;
	wire [AW-1:0] ridx;
	reg  [31:0] own_rdata;
	integer     k;

	// Decode a 4-byte aligned port match
	function port_hit;
		input [15:0] a;
		input [15:0] base;
		begin
			port_hit = ((a & `CAP_PORT_BASE_MASK) == base);
		end
	endfunction

	// Type 0 device decode: one idsel line high on AD[31:11] for devices 0 to 20, none for higher devices
	function [31:0] idsel_decode;
		input [4:0] dev;
		begin
			idsel_decode = `CAP_IDSEL_BASE << dev;
		end
	endfunction

	assign bus_select      = config_address_reg_q[`CAP_BUS_HI:`CAP_BUS_LO];
	assign dev_select      = config_address_reg_q[`CAP_DEV_HI:`CAP_DEV_LO];
	assign function_select = config_address_reg_q[`CAP_FUNC_HI:`CAP_FUNC_LO];
	assign register_select = config_address_reg_q[`CAP_REG_HI:`CAP_REG_LO];
	assign ridx            = register_select[AW-1:0];

	assign hit_addr   = port_hit(i_io_addr, `CAP_ADDR_REG_PORT);
	assign hit_win    = port_hit(i_io_addr, `CAP_DATA_WIN_PORT) &
		config_address_reg_q[`CAP_EN_BIT];
	assign addr_dword = (i_io_be == `CAP_BE_ALL);
	assign host_dev   = (dev_select == `CAP_DEV_HOST);
	assign vbr_dev    = (dev_select == `CAP_DEV_VBRIDGE);
	assign own_dev    = (bus_select == `CAP_BUS_ZERO) & (host_dev | vbr_dev);
	// Own devices answer only function zero
	assign own_access = hit_win & own_dev & (function_select == `CAP_FUNC_ZERO);
	assign reg0_sel   = (register_select == `CAP_REG_ZERO);

	// Every host cycle completes in the cycle it is presented
	assign o_io_done = i_io_req;

	// Two logical sets: word 0 of each is a real RO/RWC dword, rest of the host set is storage
	cap_cfg_word #(
		.RESET_VAL (`CAP_CFG_RESET),
		.RO_MASK   (`CAP_W0_RO_MASK),
		.WC_MASK   (`CAP_W0_WC_MASK)
	) u_host_w0 (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_wr      (i_io_req & i_io_wr & own_access & host_dev & reg0_sel),
		.i_be      (i_io_be),
		.i_wdata   (i_io_wdata),
		.i_set     (i_host_set),
		.o_value   (host_word)
	);

	cap_cfg_word #(
		.RESET_VAL (`CAP_CFG_RESET),
		.RO_MASK   (`CAP_W0_RO_MASK),
		.WC_MASK   (`CAP_W0_WC_MASK)
	) u_vbr_w0 (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_wr      (i_io_req & i_io_wr & own_access & vbr_dev & reg0_sel),
		.i_be      (i_io_be),
		.i_wdata   (i_io_wdata),
		.i_set     (i_vbr_set),
		.o_value   (vbr_word)
	);

	// Address register: dword writes only, reserved bits held at zero
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			config_address_reg_q <= `CAP_ADDR_RESET;
		end else if (i_io_req && i_io_wr && hit_addr && addr_dword) begin
			config_address_reg_q <= i_io_wdata & `CAP_ADDR_WMASK;
		end
	end

	// Remaining dwords of the host set are plain storage, byte-lane writable
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			for (k = 0; k < NREGS; k = k + 1) begin
				ram_q[k] <= `CAP_CFG_RESET;
			end
		end else if (i_io_req && i_io_wr && own_access && host_dev && !reg0_sel) begin
			for (k = 0; k < 4; k = k + 1) begin
				if (i_io_be[k]) begin
					ram_q[ridx][8*k +: 8] <= i_io_wdata[8*k +: 8];
				end
			end
		end
	end

	// Own read data; virtual bridge beyond word 0 reads as zero (reserved)
	always @* begin
		own_rdata = 32'h00000000;
		if (host_dev) begin
			own_rdata = reg0_sel ? host_word : ram_q[ridx];
		end else if (reg0_sel) begin
			own_rdata = vbr_word;
		end
	end

	// Read data is registered; it follows the completing cycle by one clock
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_io_rdata <= 32'h00000000;
		end else if (i_io_req && !i_io_wr) begin
			if (hit_addr && addr_dword) begin
				o_io_rdata <= config_address_reg_q;
			end else if (own_access) begin
				o_io_rdata <= own_rdata;
			end else begin
				o_io_rdata <= 32'h00000000;
			end
		end
	end

	// Routing of everything the port does not claim itself
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_fwd_valid        <= 1'b0;
			o_fwd_io           <= 1'b0;
			o_fwd_cfg_type0    <= 1'b0;
			o_fwd_cfg_type1    <= 1'b0;
			o_fwd_master_abort <= 1'b0;
			o_fwd_addr         <= 32'h00000000;
			o_fwd_wr           <= 1'b0;
			o_fwd_be           <= 4'h0;
			o_fwd_wdata        <= 32'h00000000;
		end else begin
			o_fwd_valid        <= 1'b0;
			o_fwd_io           <= 1'b0;
			o_fwd_cfg_type0    <= 1'b0;
			o_fwd_cfg_type1    <= 1'b0;
			o_fwd_master_abort <= 1'b0;
			o_fwd_wr           <= i_io_wr;
			o_fwd_be           <= i_io_be;
			o_fwd_wdata        <= i_io_wdata;
			if (i_io_req) begin
				if (hit_addr && !addr_dword) begin
					// Partial access passes through as plain I/O
					o_fwd_valid <= 1'b1;
					o_fwd_io    <= 1'b1;
					o_fwd_addr  <= {16'h0000, i_io_addr};
				end else if (!hit_addr && !hit_win) begin
					// Includes the data window while disabled
					o_fwd_valid <= 1'b1;
					o_fwd_io    <= 1'b1;
					o_fwd_addr  <= {16'h0000, i_io_addr};
				end else if (hit_win && own_dev && !own_access) begin
					o_fwd_master_abort <= 1'b1;
				end else if (hit_win && !own_dev && bus_select == `CAP_BUS_ZERO) begin
					o_fwd_valid     <= 1'b1;
					o_fwd_cfg_type0 <= 1'b1;
					o_fwd_addr      <= idsel_decode(dev_select) |
						{21'h000000, function_select, register_select,
						`CAP_TYPE0_CODE};
				end else if (hit_win && !own_dev) begin
					// Other buses: type 1 with the full selection word
					o_fwd_valid     <= 1'b1;
					o_fwd_cfg_type1 <= 1'b1;
					o_fwd_addr      <= {8'h00,
						config_address_reg_q[`CAP_BUS_HI:`CAP_REG_LO],
						`CAP_TYPE1_CODE};
				end
			end
		end
	end

	assign o_config_enable_bit  = config_address_reg_q[`CAP_EN_BIT];
	assign o_config_address_reg = config_address_reg_q;
endmodule // cap_config_access_port

// ==== rtl/cap_consts.vh ====
// Constants for the configuration access port
`ifndef CAP_CONSTS_VH
`define CAP_CONSTS_VH
`define CAP_ADDR_REG_PORT   16'h0CF8
`define CAP_DATA_WIN_PORT   16'h0CFC
`define CAP_PORT_BASE_MASK  16'hFFFC
`define CAP_ADDR_RESET      32'h00000000
`define CAP_ADDR_WMASK      32'h80FFFFFC
`define CAP_EN_BIT          31
`define CAP_BUS_HI          23
`define CAP_BUS_LO          16
`define CAP_DEV_HI          15
`define CAP_DEV_LO          11
`define CAP_FUNC_HI         10
`define CAP_FUNC_LO         8
`define CAP_REG_HI          7
`define CAP_REG_LO          2
`define CAP_BUS_ZERO        8'h00
`define CAP_FUNC_ZERO       3'h0
`define CAP_DEV_HOST        5'h00
`define CAP_DEV_VBRIDGE     5'h01
`define CAP_BE_ALL          4'hF
`define CAP_RO_MASK         32'hFFFFFFFF
`define CAP_WC_MASK         32'h00000000
`define CAP_CFG_RESET       32'h00000000
`define CAP_W0_RO_MASK      32'hFFFF0000
`define CAP_W0_WC_MASK      32'h0000FFFF
`define CAP_REG_ZERO        6'h00
`define CAP_IDSEL_BASE      32'h00000800
`define CAP_TYPE0_CODE      2'b00
`define CAP_TYPE1_CODE      2'b01
`endif

// ==== rtl/cap_cfg_word.v ====
// One configuration dword with read-only, read/write and write-one-clear bits
`timescale 1ns/10ps
`include "cap_consts.vh"
module cap_cfg_word #(
	parameter [31:0] RESET_VAL = `CAP_CFG_RESET,
	parameter [31:0] RO_MASK   = `CAP_RO_MASK,
	parameter [31:0] WC_MASK   = `CAP_WC_MASK
) (
	// Clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rstn,
	// Write port
	input  wire        i_wr,
	input  wire [3:0]  i_be,
	input  wire [31:0] i_wdata,
	input  wire [31:0] i_set,
	// State
	output wire [31:0] o_value
);
	reg  [31:0] word_q;
	reg  [31:0] word_d;
	wire [31:0] lane_mask;
	genvar g;

	generate
		for (g = 0; g < 4; g = g + 1) begin : g_lane
			// Byte lane g holds bits 8g+7..8g: low address carries low bits
			assign lane_mask[8*g+7:8*g] = {8{i_wr & i_be[g]}};
		end
	endgenerate

	always @* begin
		word_d = word_q;
		// Plain read/write bits take the written value where enabled
		word_d = (word_d & ~(lane_mask & ~RO_MASK & ~WC_MASK)) |
			(i_wdata & lane_mask & ~RO_MASK & ~WC_MASK);
		// A written 1 clears, a written 0 leaves the bit alone
		word_d = word_d & ~(i_wdata & lane_mask & WC_MASK);
		// Hardware set beats a same-cycle clear so no event is lost
		word_d = word_d | (i_set & WC_MASK);
	end

	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			word_q <= RESET_VAL;
		end else begin
			word_q <= word_d;
		end
	end

	assign o_value = word_q;
endmodule // cap_cfg_word

// ==== bench/cap_port_monitor.sv ====
// Checker for the configuration access port
`timescale 1ns/10ps
`include "cap_consts.vh"
module cap_port_monitor (
	// Clock and reset
	input wire        i_clk_sys,
	input wire        i_rstn,
	// Host cycle
	input wire        i_io_req,
	input wire        i_io_wr,
	input wire [15:0] i_io_addr,
	input wire [3:0]  i_io_be,
	input wire [31:0] i_io_wdata,
	// Results
	input wire        o_io_done,
	input wire        o_config_enable_bit,
	input wire [31:0] o_config_address_reg,
	input wire        o_fwd_valid,
	input wire        o_fwd_io,
	input wire        o_fwd_cfg_type0,
	input wire        o_fwd_master_abort,
	input wire [31:0] o_fwd_addr
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);
	wire [31:0] ar  = o_config_address_reg;
	wire [5:0]  rs  = ar[7:2];
	wire        ap  = i_io_req && i_io_addr == `CAP_ADDR_REG_PORT;
	wire        win = i_io_req && (i_io_addr & `CAP_PORT_BASE_MASK) == `CAP_DATA_WIN_PORT;
	wire        on  = win && o_config_enable_bit;
	// Bus 0 with device 0 or 1 is this device
	wire        own = ar[23:12] == 12'h000;
	a_done_same: assert property (o_io_done == i_io_req)
		else $error("done not in request cycle");
	a_addr_reset: assert property (!$past(i_rstn) |-> ar == 32'h0)
		else $error("address register not cleared");
	a_dword_store: assert property (ap && i_io_wr && i_io_be == 4'hF |=>
		ar == ($past(i_io_wdata) & `CAP_ADDR_WMASK)) else $error("address write lost");
	a_enable_bit: assert property (ap && i_io_wr && i_io_be == 4'hF |=>
		o_config_enable_bit == $past(i_io_wdata[31])) else $error("enable bit wrong");
	a_part_pass: assert property (ap && i_io_be != 4'hF |=>
		$stable(ar) && o_fwd_io && o_fwd_valid) else $error("partial access claimed");
	a_off_io: assert property (win && !o_config_enable_bit |=>
		o_fwd_io && o_fwd_addr == {16'h0, $past(i_io_addr)}) else $error("window not io");
	a_window_on: assert property (on && own && ar[10:8] == 3'h0 |=> !o_fwd_valid)
		else $error("own access forwarded");
	a_func_abort: assert property (on && own && ar[10:8] != 3'h0 |=>
		o_fwd_master_abort && !o_fwd_valid) else $error("no master abort");
	a_type0_addr: assert property (on && ar[23:16] == 8'h00 && ar[15:12] != 4'h0 |=>
		o_fwd_cfg_type0 && o_fwd_addr[7:2] == $past(rs)) else $error("type 0 cycle wrong");
	c_part: cover property (ap && i_io_be != 4'hF);
	c_abort: cover property (o_fwd_master_abort);
	c_type0: cover property (o_fwd_cfg_type0);
endmodule // cap_port_monitor
bind cap_config_access_port cap_port_monitor u_mon (
	.i_clk_sys            (i_clk_sys),
	.i_rstn               (i_rstn),
	.i_io_req             (i_io_req),
	.i_io_wr              (i_io_wr),
	.i_io_addr            (i_io_addr),
	.i_io_be              (i_io_be),
	.i_io_wdata           (i_io_wdata),
	.o_io_done            (o_io_done),
	.o_config_enable_bit  (o_config_enable_bit),
	.o_config_address_reg (o_config_address_reg),
	.o_fwd_valid          (o_fwd_valid),
	.o_fwd_io             (o_fwd_io),
	.o_fwd_cfg_type0      (o_fwd_cfg_type0),
	.o_fwd_master_abort   (o_fwd_master_abort),
	.o_fwd_addr           (o_fwd_addr)
);

// ==== bench/cap_host_model.sv ====
// Host processor model issuing I/O cycles
`timescale 1ns/10ps
module cap_host_model (
	// Clock
	input  wire        i_clk_sys,
	// Host I/O cycle
	output reg         o_req,
	output reg         o_wr,
	output reg  [15:0] o_addr,
	output reg  [3:0]  o_be,
	output reg  [31:0] o_wdata
);
	initial begin
		o_req = 1'h0;
		o_wr = 1'h0;
		o_addr = 16'h0000;
		o_be = 4'h0;
		o_wdata = 32'h0;
	end
	// Sole master, so cycles never overlap address writes skip read-merge
	task cyc(input w, input [15:0] a, input [3:0] b, input [31:0] d);
		begin
			o_req <= 1'h1;
			o_wr <= w;
			o_addr <= a;
			o_be <= b;
			o_wdata <= d;
			@(posedge i_clk_sys);
			o_req <= 1'h0;
			// Released address and data lines show junk so stale values cannot pass
			o_addr <= ~a;
			o_wdata <= ~d;
			#1;
		end
	endtask
endmodule // cap_host_model

// ==== bench/cap_config_access_port_tb_top.sv ====
// Testbench for the configuration access port
`timescale 1ns/10ps
module cap_config_access_port_tb_top;
	reg         i_clk_sys = 1'h0;
	reg         i_rstn = 1'h0;
	reg  [31:0] hset = 32'h0;
	reg  [31:0] vset = 32'h0;
	wire        req, wr, done, en, fv, fio, ft0, ft1, fab, fwr;
	wire [15:0] addr;
	wire [3:0]  be, fbe;
	wire [31:0] wd, rd, fad, fwd, ar;
	integer     failures = 0;
	integer     num_checks = 0;
	integer     cycles = 0;
	integer     i;
	always #20 i_clk_sys = ~i_clk_sys;
	cap_host_model u_host (.i_clk_sys(i_clk_sys), .o_req(req), .o_wr(wr), .o_addr(addr),
		.o_be(be), .o_wdata(wd));
	cap_config_access_port DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_io_req(req),
		.i_io_wr(wr), .i_io_addr(addr), .i_io_be(be), .i_io_wdata(wd), .o_io_done(done),
		.o_io_rdata(rd), .i_host_set(hset), .i_vbr_set(vset), .o_fwd_valid(fv),
		.o_fwd_io(fio), .o_fwd_cfg_type0(ft0), .o_fwd_cfg_type1(ft1),
		.o_fwd_master_abort(fab), .o_fwd_addr(fad), .o_fwd_wr(fwr), .o_fwd_be(fbe),
		.o_fwd_wdata(fwd), .o_config_enable_bit(en), .o_config_address_reg(ar));
	task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("wrong value %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task acc(input w, input [15:0] a, input [3:0] b, input [31:0] d);
		begin
			@(posedge i_clk_sys);
			u_host.cyc(w, a, b, d);
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	always @(posedge i_clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 400) begin
			failures = failures + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (4) @(posedge i_clk_sys);
		i_rstn <= 1'h1;
		#1 check("addr", ar, 32'h0);
		acc(1'h1, 16'h0CF8, 4'hF, 32'hFFFFFFFF);
		check("en", {31'h0, en}, 32'h1);
		acc(1'h0, 16'h0CF8, 4'hF, 32'h0);
		check("addr_rd", rd, 32'h80FFFFFC);
		for (i = 1; i < 4; i = i + 2) begin
			acc(1'h1, 16'h0CF8, i[3:0], 32'h0);
			check("pass", {fv, fio, fad[29:0]}, 32'hC0000CF8);
			check("pass_be", {28'h0, fbe}, {28'h0, i[3:0]});
			check("keep", ar, 32'h80FFFFFC);
		end
		acc(1'h1, 16'h0CF8, 4'hF, 32'h8);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("off", {fio, fad[30:0]}, 32'h80000CFC);
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80000008);
		for (i = 0; i < 4; i = i + 1)
			acc(1'h1, 16'h0CFC + i[15:0], 4'h1 << i, 32'h12345678);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("lanes", rd, 32'h12345678);
		check("no_fwd", {31'h0, fv}, 32'h0);
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80000000);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("w0_rst", rd, 32'h0);
		@(posedge i_clk_sys);
		hset <= 32'hFFFFFFFF;
		vset <= 32'hFFFFFFFF;
		@(posedge i_clk_sys);
		hset <= 32'h0;
		vset <= 32'h0;
		acc(1'h1, 16'h0CFC, 4'hF, 32'hFFFF00F0);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("w1c", rd, 32'h0000FF0F);
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80000800);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("vbr", rd, 32'h0000FFFF);
		// Unimplemented word written, still below the device-specific region
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80000814);
		acc(1'h1, 16'h0CFC, 4'hF, 32'hFFFFFFFF);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("rsvd", rd, 32'h0);
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80000100);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("abort", {30'h0, fab, fv}, 32'h2);
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80001A14);
		acc(1'h0, 16'h0CFC, 4'hF, 32'h0);
		check("type0", {ft0, fad[30:0]}, 32'h80004214);
		acc(1'h1, 16'h0CF8, 4'hF, 32'h80051A14);
		acc(1'h1, 16'h0CFC, 4'hF, 32'hAA55AA55);
		check("type1", {ft1, fwr, fad[29:0]}, 32'hC0051A15);
		check("fwd_data", fwd, 32'hAA55AA55);
		check("fwd_be", {28'h0, fbe}, 32'hF);
		@(posedge i_clk_sys);
		i_rstn <= 1'h0;
		@(posedge i_clk_sys);
		i_rstn <= 1'h1;
		#1 check("hard_rst", ar, 32'h0);
		report_and_stop;
	end
endmodule // cap_config_access_port_tb_top
